/* pbsr_pkg.sv */
// Purpose: shared constants and types for the basic status word block
// Assumes: management frames arrive on a sampled serial clock and data pin
// Notes: the status word is read-only; writes are decoded and dropped
package pbsr_pkg;

    // management register address of the status word
    localparam logic [4:0] REG_ADDR = 5'h01;

    // bits that never change: 14..11, 8, 6, 3 and 0 read one
    localparam logic [15:0] FIXED_WORD = 16'h7949;
    // bits driven by live monitors
    localparam logic [15:0] DYN_MASK = 16'h0036;

    localparam int BIT_T4 = 15;
    localparam int BIT_T2_FD = 10;
    localparam int BIT_T2_HD = 9;
    localparam int BIT_EXT_STAT = 8;
    localparam int BIT_RSVD = 7;
    localparam int BIT_PRE_SUP = 6;
    localparam int BIT_AN_DONE = 5;
    localparam int BIT_RFAULT = 4;
    localparam int BIT_AN_ABLE = 3;
    localparam int BIT_LINK = 2;
    localparam int BIT_JABBER = 1;
    localparam int BIT_EXT_CAP = 0;

    // frame layout
    localparam logic [5:0] PREAMBLE_LEN = 6'h20;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] TA_WRITE = 2'h2;
    localparam logic [4:0] OP_LAST = 5'h01;
    localparam logic [4:0] ADDR_LAST = 5'h09;
    localparam logic [4:0] TA_LAST = 5'h01;
    localparam logic [4:0] DATA_LAST = 5'h0f;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_START = 7'h02,
        ST_OP = 7'h04,
        ST_ADDR = 7'h08,
        ST_TA = 7'h10,
        ST_RDATA = 7'h20,
        ST_WDATA = 7'h40
    } pbsr_state_e;

    // inputs from the link, negotiation, fault and jabber monitors
    typedef struct packed {
        logic an_complete;
        logic far_end_fault;
        logic lp_remote_fault;
        logic link_good;
        logic jabber;
        logic speed_10m;
    } pbsr_mon_s;

    typedef struct packed {
        logic an_done;
        logic rfault;
        logic link;
        logic jab;
    } pbsr_lat_s;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        logic [1:0] val;
    } pbsr_sync_s;

    typedef struct packed {
        pbsr_state_e st;
        logic pre_ok;
        logic [5:0] ones;
        logic [4:0] cnt;
        logic [1:0] op;
        logic [9:0] addr;
        logic is_rd;
        logic hit;
        logic [15:0] shreg;
        logic mdc_prev;
        logic mdio_o;
        logic mdio_oe_n;
        logic rd_pulse;
    } pbsr_mdio_s;

endpackage

/* pbsr_station.sv */
// Purpose: management station model driving the serial clock and data line
// Assumes: called between frames only; the clock stands low outside frames
// Notes: changes land on falling ref_clk edges; released line reads high (pull-up)
`timescale 1ns/1ps
module pbsr_station (
    input wire logic ref_clk,
    output logic mdc,
    output logic st_drv,
    output logic st_val,
    input wire logic mdio_line
);
    // half period in ref_clk cycles; raised by the bench for a slow station
    int hp = 4;

    initial
    begin
        mdc = 1'b0;
        st_drv = 1'b0;
        st_val = 1'b1;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // line sampled just before the rise, so the device has settled its bit
    task automatic bit_cyc(input logic drv, input logic v, output logic smp);
        st_drv = drv;
        st_val = v;
        wait_n(hp);
        smp = mdio_line;
        mdc = 1'b1;
        wait_n(hp);
        mdc = 1'b0;
    endtask

    task automatic xfer(input logic pre, input logic [1:0] op, input logic [1:0] ta,
                        input logic [9:0] ad, input logic [15:0] wd,
                        output logic [15:0] rd, output logic ta_smp);
        logic [31:0] fr;
        logic smp;
        logic rdf;
        fr = {2'h1, op, ad, ta, wd};
        rdf = (op == 2'h2);
        rd = 16'h0000;
        ta_smp = 1'b1;
        if (pre)
            repeat (32) bit_cyc(1'b1, 1'b1, smp);
        for (int i = 31; i >= 0; i--)
        begin
            // reads hand the line over from the first turnaround bit
            bit_cyc(!(rdf && i < 18), fr[i], smp);
            if (i == 16)
                ta_smp = smp;
            if (i < 16)
                rd[i] = smp;
        end
        // idle gap, then one rise with line high
        st_drv = 1'b0;
        wait_n(50);
        // line stays driven high until the next frame takes it over
        bit_cyc(1'b1, 1'b1, smp);
    endtask
endmodule

/* pbsr_status.sv */
// Purpose: latched and live bits of the basic status word
// Assumes: monitor inputs are on ref_clk; rd_pulse marks a captured read
// Notes: word is a plain concatenation of flops and constants
`timescale 1ns/1ps
module pbsr_status (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire pbsr_pkg::pbsr_mon_s mon,
    input wire logic rd_pulse,
    output logic [15:0] word
);

    pbsr_pkg::pbsr_lat_s q, n;

    always_comb
    begin
        n = q;
        // [RL8] live completion flag
        n.an_done = mon.an_complete;
        // [RL9] fault latches high, event beats clear
        n.rfault = (q.rfault & ~rd_pulse) | mon.far_end_fault | mon.lp_remote_fault;
        // [RL11] latch low, read reloads current link
        n.link = rd_pulse ? mon.link_good : (q.link & mon.link_good);
        // [RL12] [RL13] jabber only counts at 10 Mb/s
        n.jab = (q.jab & ~rd_pulse) | (mon.jabber & mon.speed_10m);
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            q <= '0;
        end
        else
        begin
            q <= n;
        end
    end

    always_comb
    begin
        // [RL2] [RL3] [RL4] [RL5] [RL6] [RL10] [RL14] constant bits
        word = pbsr_pkg::FIXED_WORD;
        word[pbsr_pkg::BIT_AN_DONE] = q.an_done;
        word[pbsr_pkg::BIT_RFAULT] = q.rfault;
        word[pbsr_pkg::BIT_LINK] = q.link;
        word[pbsr_pkg::BIT_JABBER] = q.jab;
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    property p_rfault_latch;
        (mon.far_end_fault || mon.lp_remote_fault) |=> word[pbsr_pkg::BIT_RFAULT] [*1];
    endproperty
    a_rfault_latch: assert property (p_rfault_latch) else $error("remote fault not latched"); // [RL9]

    property p_rfault_hold;
        (word[pbsr_pkg::BIT_RFAULT] && !rd_pulse) |=> word[pbsr_pkg::BIT_RFAULT];
    endproperty
    a_rfault_hold: assert property (p_rfault_hold) else $error("remote fault dropped early"); // [RL9]

    property p_link_fail;
        !mon.link_good |=> !word[pbsr_pkg::BIT_LINK];
    endproperty
    a_link_fail: assert property (p_link_fail) else $error("link bit not cleared"); // [RL11]

    property p_link_needs_read;
        (!word[pbsr_pkg::BIT_LINK] && !rd_pulse) |=> !word[pbsr_pkg::BIT_LINK];
    endproperty
    a_link_needs_read: assert property (p_link_needs_read) else $error("link set w/o read"); // [RL11]

    property p_jab_10m;
        (!word[pbsr_pkg::BIT_JABBER] && !(mon.jabber && mon.speed_10m))
            |=> !word[pbsr_pkg::BIT_JABBER];
    endproperty
    a_jab_10m: assert property (p_jab_10m) else $error("jabber set outside 10M"); // [RL12]

    property p_jab_clear;
        (rd_pulse && !mon.jabber) |=> !word[pbsr_pkg::BIT_JABBER];
    endproperty
    a_jab_clear: assert property (p_jab_clear) else $error("jabber not cleared on read"); // [RL13]

    property p_an_done;
        mon.an_complete |=> word[pbsr_pkg::BIT_AN_DONE];
    endproperty
    a_an_done: assert property (p_an_done) else $error("completion flag missing"); // [RL8]

endmodule

/* pbsr_sync3.sv */
// Purpose: three-stage synchroniser for the serial clock and data pins
// Assumes: inputs are asynchronous to ref_clk
// Notes: a new level is taken only when stages two and three agree
`timescale 1ns/1ps
module pbsr_sync3 (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [1:0] din,
    output logic [1:0] dout
);

    pbsr_pkg::pbsr_sync_s q, n;

    always_comb
    begin
        n = q;
        n.s1 = din;
        n.s2 = q.s1;
        n.s3 = q.s2;
        for (int i = 0; i < 2; i++)
        begin
            if (q.s2[i] == q.s3[i])
            begin
                n.val[i] = q.s3[i];
            end
        end
    end

    // reset loads both pins high; the data line idles high, the station clock idles low
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            q <= '{s1: 2'h3, s2: 2'h3, s3: 2'h3, val: 2'h3};
        end
        else
        begin
            q <= n;
        end
    end

    assign dout = q.val;

endmodule

/* pbsr_top.sv */
// What this block does
// [RL1] The status word answers at management address 1 and ignores all writes.
// [RL2] Bits 14 to 11 always read one for the 100 and 10 Mb/s abilities.
// [RL3] Bits 15, 10 and 9 always read zero for the absent T4 and T2 modes.
// [RL4] Bit 8 always reads one to show that the extended status register exists.
// [RL5] Bit 7 reads zero and the station writes it only as zero.
// [RL6] Bit 6 reads one and frames need a 32-bit preamble only after reset or a bad frame.
// [RL7] The station idles 500 ns and gives one clock edge with data high between frames.
// [RL8] Bit 5 follows completion of auto-negotiation.
// [RL9] Bit 4 latches a remote fault until a read or reset.
// [RL10] Bit 3 always reads one for auto-negotiation ability.
// [RL11] Bit 2 latches low on link failure and is set again only by a read with good link.
// [RL12] Jabber is recorded only while the port runs at 10 Mb/s.
// [RL13] Bit 1 latches jabber until a read or reset.
// [RL14] Bit 0 always reads one for extended register capability.
// [RL15] A read returns the latched bits and clears them only after capture.
//
// Purpose: serial management slave for the basic status word
// Assumes: mdc and mdio are pins sampled by ref_clk at 100 MHz
// Notes: other register addresses are left undriven for other blocks
`timescale 1ns/1ps
module pbsr_top #(
    parameter logic [4:0] PHY_ADDR = 5'h00
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic mdc,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_n,
    input wire pbsr_pkg::pbsr_mon_s mon
);

    pbsr_pkg::pbsr_mdio_s q, n;
    logic [1:0] pins_f;
    logic [15:0] word;
    logic mdc_f;
    logic bit_in;
    logic rise;
    logic [1:0] op_now;
    logic [9:0] addr_now;

    pbsr_sync3 u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .din({mdc, mdio_i}),
        .dout(pins_f)
    );

    pbsr_status u_status (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .mon(mon),
        // [RL15] clear lands on the capture edge, so no event slips between
        .rd_pulse(n.rd_pulse),
        .word(word)
    );

    assign mdc_f = pins_f[1];
    assign bit_in = pins_f[0];
    assign rise = mdc_f & ~q.mdc_prev;
    assign op_now = {q.op[0], bit_in};
    assign addr_now = {q.addr[8:0], bit_in};

    always_comb
    begin
        n = q;
        n.rd_pulse = 1'b0;
        n.mdc_prev = mdc_f;
        if (rise)
        begin
            unique case (q.st)
                pbsr_pkg::ST_IDLE:
                begin
                    if (bit_in)
                    begin
                        if (q.ones != pbsr_pkg::PREAMBLE_LEN)
                        begin
                            n.ones = q.ones + 6'h01;
                        end
                    end
                    // [RL6] skip preamble once one full run was seen
                    else if (q.pre_ok || q.ones == pbsr_pkg::PREAMBLE_LEN)
                    begin
                        n.pre_ok = 1'b1;
                        n.st = pbsr_pkg::ST_START;
                        n.ones = 6'h00;
                    end
                    else
                    begin
                        n.ones = 6'h00;
                    end
                end
                pbsr_pkg::ST_START:
                begin
                    n.st = bit_in ? pbsr_pkg::ST_OP : pbsr_pkg::ST_IDLE;
                    n.cnt = 5'h00;
                end
                pbsr_pkg::ST_OP:
                begin
                    n.op = op_now;
                    n.cnt = q.cnt + 5'h01;
                    if (q.cnt == pbsr_pkg::OP_LAST)
                    begin
                        n.cnt = 5'h00;
                        if (op_now == pbsr_pkg::OP_READ || op_now == pbsr_pkg::OP_WRITE)
                        begin
                            n.st = pbsr_pkg::ST_ADDR;
                            n.is_rd = (op_now == pbsr_pkg::OP_READ);
                        end
                        else
                        begin
                            // [RL6] bad opcode forces a fresh preamble
                            n.pre_ok = 1'b0;
                            n.st = pbsr_pkg::ST_IDLE;
                        end
                    end
                end
                pbsr_pkg::ST_ADDR:
                begin
                    n.addr = addr_now;
                    n.cnt = q.cnt + 5'h01;
                    if (q.cnt == pbsr_pkg::ADDR_LAST)
                    begin
                        n.cnt = 5'h00;
                        n.st = pbsr_pkg::ST_TA;
                        // [RL1] decode own address and register
                        n.hit = (addr_now == {PHY_ADDR, pbsr_pkg::REG_ADDR});
                    end
                end
                pbsr_pkg::ST_TA:
                begin
                    n.op = op_now;
                    n.cnt = q.cnt + 5'h01;
                    if (q.cnt != pbsr_pkg::TA_LAST)
                    begin
                        if (q.is_rd && q.hit)
                        begin
                            // [RL15] capture first, clear latches after
                            n.shreg = word;
                            n.rd_pulse = 1'b1;
                            n.mdio_oe_n = 1'b0;
                            n.mdio_o = 1'b0;
                        end
                    end
                    else
                    begin
                        n.cnt = 5'h00;
                        if (q.is_rd)
                        begin
                            n.st = pbsr_pkg::ST_RDATA;
                            if (q.hit)
                            begin
                                n.mdio_o = q.shreg[15];
                                n.shreg = {q.shreg[14:0], 1'b0};
                            end
                        end
                        else if (op_now == pbsr_pkg::TA_WRITE)
                        begin
                            n.st = pbsr_pkg::ST_WDATA;
                        end
                        else
                        begin
                            // [RL6] bad turnaround forces a fresh preamble
                            n.pre_ok = 1'b0;
                            n.st = pbsr_pkg::ST_IDLE;
                        end
                    end
                end
                pbsr_pkg::ST_RDATA:
                begin
                    n.cnt = q.cnt + 5'h01;
                    if (q.cnt == pbsr_pkg::DATA_LAST)
                    begin
                        // release after the last bit period
                        n.mdio_oe_n = 1'b1;
                        n.mdio_o = 1'b1;
                        n.st = pbsr_pkg::ST_IDLE;
                    end
                    else if (q.hit)
                    begin
                        n.mdio_o = q.shreg[15];
                        n.shreg = {q.shreg[14:0], 1'b0};
                    end
                end
                pbsr_pkg::ST_WDATA:
                begin
                    // [RL1] [RL5] write data is counted and dropped
                    n.cnt = q.cnt + 5'h01;
                    if (q.cnt == pbsr_pkg::DATA_LAST)
                    begin
                        // [RL7] back to idle; with the preamble skip armed, a zero start bit is taken at once, with no idle high edge needed
                        n.st = pbsr_pkg::ST_IDLE;
                    end
                end
                default:
                begin
                    n.st = pbsr_pkg::ST_IDLE;
                    n.mdio_oe_n = 1'b1;
                    n.mdio_o = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            q <= '{st: pbsr_pkg::ST_IDLE, pre_ok: 1'b0, ones: 6'h00, cnt: 5'h00,
                   op: 2'h0, addr: 10'h000, is_rd: 1'b0, hit: 1'b0, shreg: 16'h0000,
                   mdc_prev: 1'b1, mdio_o: 1'b1, mdio_oe_n: 1'b1, rd_pulse: 1'b0};
        end
        else
        begin
            q <= n;
        end
    end

    assign mdio_o = q.mdio_o;
    assign mdio_oe_n = q.mdio_oe_n;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    property p_fixed_ones;
        (word & ~pbsr_pkg::DYN_MASK) == pbsr_pkg::FIXED_WORD;
    endproperty
    a_fixed_ones: assert property (p_fixed_ones) else $error("fixed ability bits wrong"); // [RL2]

    property p_no_t4_t2;
        !word[pbsr_pkg::BIT_T4] && !word[pbsr_pkg::BIT_T2_FD] && !word[pbsr_pkg::BIT_T2_HD];
    endproperty
    a_no_t4_t2: assert property (p_no_t4_t2) else $error("absent mode bit reads one"); // [RL3]

    property p_ext_status;
        word[pbsr_pkg::BIT_EXT_STAT] && word[pbsr_pkg::BIT_PRE_SUP];
    endproperty
    a_ext_status: assert property (p_ext_status) else $error("ext status bit low"); // [RL4]

    property p_rsvd_zero;
        q.rd_pulse |-> !q.shreg[pbsr_pkg::BIT_RSVD];
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read one"); // [RL5]

    property p_an_able;
        word[pbsr_pkg::BIT_AN_ABLE] && word[pbsr_pkg::BIT_EXT_CAP];
    endproperty
    a_an_able: assert property (p_an_able) else $error("ability bits low"); // [RL10]

    property p_ext_cap;
        q.rd_pulse |-> q.shreg[pbsr_pkg::BIT_EXT_CAP];
    endproperty
    a_ext_cap: assert property (p_ext_cap) else $error("ext capability read low"); // [RL14]

    property p_capture;
        q.rd_pulse |-> q.shreg == $past(word);
    endproperty
    a_capture: assert property (p_capture) else $error("read did not hold old word"); // [RL15]

    property p_drive_only_hit;
        !q.mdio_oe_n |-> (q.is_rd && q.hit);
    endproperty
    a_drive_only_hit: assert property (p_drive_only_hit) else $error("drove on miss or write"); // [RL1]

    sequence s_bad_op;
        rise && q.st == pbsr_pkg::ST_OP && q.cnt == pbsr_pkg::OP_LAST
            && op_now != pbsr_pkg::OP_READ && op_now != pbsr_pkg::OP_WRITE;
    endsequence
    sequence s_rearm;
        !q.pre_ok && q.st == pbsr_pkg::ST_IDLE;
    endsequence
    property p_bad_op;
        s_bad_op |=> s_rearm;
    endproperty
    a_bad_op: assert property (p_bad_op) else $error("bad opcode kept preamble skip"); // [RL6]

    sequence s_bad_ta;
        rise && q.st == pbsr_pkg::ST_TA && q.cnt == pbsr_pkg::TA_LAST && !q.is_rd
            && op_now != pbsr_pkg::TA_WRITE;
    endsequence
    property p_bad_ta;
        s_bad_ta |=> s_rearm;
    endproperty
    a_bad_ta: assert property (p_bad_ta) else $error("bad turnaround kept skip"); // [RL6]

    property p_no_pre;
        (rise && q.st == pbsr_pkg::ST_IDLE && !bit_in && !q.pre_ok
            && q.ones != pbsr_pkg::PREAMBLE_LEN) |=> (q.st == pbsr_pkg::ST_IDLE);
    endproperty
    a_no_pre: assert property (p_no_pre) else $error("frame w/o preamble taken"); // [RL6]

    property p_ta_drive;
        (rise && q.st == pbsr_pkg::ST_TA && q.cnt != pbsr_pkg::TA_LAST && q.is_rd && q.hit)
            |=> (!q.mdio_oe_n && !q.mdio_o && q.rd_pulse);
    endproperty
    a_ta_drive: assert property (p_ta_drive) else $error("turnaround not driven low"); // [RL15]

    property p_shift_out;
        (rise && q.st == pbsr_pkg::ST_RDATA && q.hit && q.cnt != pbsr_pkg::DATA_LAST)
            |=> (q.mdio_o == $past(q.shreg[15]));
    endproperty
    a_shift_out: assert property (p_shift_out) else $error("read bit out of order"); // [RL1]

    property p_release;
        (rise && q.st == pbsr_pkg::ST_RDATA && q.cnt == pbsr_pkg::DATA_LAST)
            |=> (q.mdio_oe_n && q.st == pbsr_pkg::ST_IDLE);
    endproperty
    a_release: assert property (p_release) else $error("line kept after read"); // [RL1]

    property p_write_quiet;
        q.st == pbsr_pkg::ST_WDATA |-> q.mdio_oe_n;
    endproperty
    a_write_quiet: assert property (p_write_quiet) else $error("drove during write"); // [RL1]

endmodule

/* tb_top.sv */
// Purpose: self-checking bench for the basic status word block
// Assumes: station model owns the serial pins; monitors driven on falling edges
// Notes: unmatched reads come back all ones because nobody drives the line
`timescale 1ns/1ps
module tb_top;
    localparam logic [4:0] PHY = 5'h05;
    localparam logic [15:0] BASE = 16'h7949;

    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic mdc;
    logic mdio_o;
    logic mdio_oe_n;
    logic st_drv;
    logic st_val;
    logic mdio_line;
    pbsr_pkg::pbsr_mon_s mon = 6'h04;
    int bad_count = 0;
    int n_compared = 0;
    logic [15:0] dummy;
    logic tdummy;

    always #5 ref_clk = ~ref_clk;

    // wire level: device when enabled, else station, else pull-up
    assign mdio_line = !mdio_oe_n ? mdio_o : (st_drv ? st_val : 1'b1);

    pbsr_top #(.PHY_ADDR(PHY)) dut_u (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .mdc(mdc),
        .mdio_i(mdio_line),
        .mdio_o(mdio_o),
        .mdio_oe_n(mdio_oe_n),
        .mon(mon)
    );

    pbsr_station st_u (
        .ref_clk(ref_clk),
        .mdc(mdc),
        .st_drv(st_drv),
        .st_val(st_val),
        .mdio_line(mdio_line)
    );

    task automatic tally_and_finish;
        if (bad_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    function automatic logic [15:0] w(input logic an, input logic rf, input logic lk,
                                      input logic jb);
        return BASE | {10'h000, an, rf, 1'b0, lk, jb, 1'b0};
    endfunction

    task automatic rd_chk(input logic pre, input logic [4:0] phy, input logic [4:0] ra,
                          input logic [15:0] exp);
        logic [15:0] d;
        logic t;
        st_u.xfer(pre, 2'h2, 2'h0, {phy, ra}, 16'h0000, d, t);
        cmp16(d, exp, "read data");
        if (exp !== 16'hffff)
            cmp1(t, 1'b0, "turnaround drive");
    endtask

    task automatic pulse_cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    initial
    begin
        pulse_cyc(16);
        rstn = 1'b1;
        pulse_cyc(4);
        rd_chk(1'b0, PHY, 5'h01, 16'hffff);
        rd_chk(1'b1, PHY, 5'h01, w(0, 0, 0, 0));
        rd_chk(1'b0, PHY, 5'h01, w(0, 0, 1, 0));
        rd_chk(1'b0, PHY, 5'h02, 16'hffff);
        rd_chk(1'b0, PHY ^ 5'h01, 5'h01, 16'hffff);
        st_u.xfer(1'b0, 2'h1, 2'h2, {PHY, 5'h01}, 16'hff7f, dummy, tdummy);
        rd_chk(1'b0, PHY, 5'h01, w(0, 0, 1, 0));
        mon.an_complete = 1'b1;
        rd_chk(1'b0, PHY, 5'h01, w(1, 0, 1, 0));
        // both fault sources, each latched and cleared by one read
        for (int k = 0; k < 2; k++)
        begin
            if (k == 0)
                mon.far_end_fault = 1'b1;
            else
                mon.lp_remote_fault = 1'b1;
            pulse_cyc(3);
            mon.far_end_fault = 1'b0;
            mon.lp_remote_fault = 1'b0;
            rd_chk(1'b0, PHY, 5'h01, w(1, 1, 1, 0));
            rd_chk(1'b0, PHY, 5'h01, w(1, 0, 1, 0));
        end
        mon.jabber = 1'b1;
        pulse_cyc(3);
        mon.jabber = 1'b0;
        rd_chk(1'b0, PHY, 5'h01, w(1, 0, 1, 0));
        mon.speed_10m = 1'b1;
        mon.jabber = 1'b1;
        pulse_cyc(3);
        mon.jabber = 1'b0;
        rd_chk(1'b0, PHY, 5'h01, w(1, 0, 1, 1));
        rd_chk(1'b0, PHY, 5'h01, w(1, 0, 1, 0));
        mon.link_good = 1'b0;
        pulse_cyc(3);
        rd_chk(1'b0, PHY, 5'h01, w(1, 0, 0, 0));
        rd_chk(1'b0, PHY, 5'h01, w(1, 0, 0, 0));
        mon.link_good = 1'b1;
        pulse_cyc(3);
        rd_chk(1'b0, PHY, 5'h01, w(1, 0, 0, 0));
        rd_chk(1'b0, PHY, 5'h01, w(1, 0, 1, 0));
        // two bad opcodes and a bad write turnaround, each disarming the skip
        for (int k = 0; k < 3; k++)
        begin
            st_u.xfer(1'b0, (k == 0) ? 2'h0 : (k == 1) ? 2'h3 : 2'h1,
                      (k == 2) ? 2'h1 : 2'h2, {PHY, 5'h01}, 16'h0000, dummy, tdummy);
            rd_chk(1'b0, PHY, 5'h01, 16'hffff);
            rd_chk(1'b1, PHY, 5'h01, w(1, 0, 1, 0));
        end
        st_u.hp = 9;
        rd_chk(1'b0, PHY, 5'h01, w(1, 0, 1, 0));
        st_u.hp = 4;
        rstn = 1'b0;
        pulse_cyc(3);
        rstn = 1'b1;
        pulse_cyc(4);
        rd_chk(1'b0, PHY, 5'h01, 16'hffff);
        rd_chk(1'b1, PHY, 5'h01, w(1, 0, 0, 0));
        tally_and_finish();
    end

    // about 30 frames of some 3 to 6 us each; generous margin
    initial
    begin
        #500000;
        bad_count++;
        tally_and_finish();
    end
endmodule
